//--- spifec_core.sv
// spifec_core: serial peripheral port with control, status and data registers
// assumes Avalon-MM master on core_clk_i; serial pins are asynchronous to it
`timescale 1ns/1ps

// Behaviour
// - idle level bit sets resting sck level
// - phase bit picks sampling and shifting edges
// - phase 0: msb first edge, ss fall starts
// - phase 1: first sck edge starts transfer
// - both ends share idle level and phase
// - master with ss active: ss low faults
// - fault: error request, disable, become slave
// - ignore bit frees ss, blocks fault
// - fault cleared by status read, control write
// - data write while busy flags collision
// - collision cleared by status then data access
// - unread bytes lost, first kept, no overrun
// - slave ss early rise flags, disable clears
// - byte done sets flag, transmit request
// - fault request only when ss not ignored
// - three rate bits pick master rate
// - bit 6 enables, bit 4 picks master
// - slave phase 0: ignore bit no effect
// - rate divides clock by 2 to 128
// - eight bits each way, msb first
// - done flag cleared by status, data read
// - slave ss high floats miso unless ignore bit set in phase 1
module spifec_core
  import spifec_pkg::*;
(
  input  wire logic                     core_clk_i,
  input  wire logic                     reset_n_i,
  input  wire logic [spifec_pkg::ADDR_W-1:0] avs_address_i,
  input  wire logic                     avs_read_i,
  input  wire logic                     avs_write_i,
  input  wire logic [spifec_pkg::DATA_W-1:0] avs_writedata_i,
  input  wire logic [3:0]               avs_byteenable_i,
  output logic      [spifec_pkg::DATA_W-1:0] avs_readdata_o,
  output logic                          avs_waitrequest_o,
  input  wire logic                     sck_i,
  output logic                          sck_o,
  output logic                          sck_oe_o,
  input  wire logic                     mosi_i,
  output logic                          mosi_o,
  output logic                          mosi_oe_o,
  input  wire logic                     miso_i,
  output logic                          miso_o,
  output logic                          miso_oe_o,
  input  wire logic                     ss_n_i,
  output logic                          tx_irq_o,
  output logic                          rx_err_irq_o
);

  import spifec_pkg::*;

  // ---- pin synchronisation
  logic [SYNC_W-1:0] pins_async;
  logic [SYNC_W-1:0] pins_sync;
  logic              sck_s;
  logic              ss_n_s;
  logic              mosi_s;
  logic              miso_s;

  assign pins_async[SYNC_SCK]  = sck_i;
  assign pins_async[SYNC_SS]   = ss_n_i;
  assign pins_async[SYNC_MOSI] = mosi_i;
  assign pins_async[SYNC_MISO] = miso_i;

  // all serial inputs pass two flops before any edge logic
  spifec_sync #(
    .WIDTH (SYNC_W)
  ) u_sync (
    .core_clk_i (core_clk_i),
    .reset_n_i  (reset_n_i),
    .async_i    (pins_async),
    .sync_o     (pins_sync)
  );

  assign sck_s  = pins_sync[SYNC_SCK];
  assign ss_n_s = pins_sync[SYNC_SS];
  assign mosi_s = pins_sync[SYNC_MOSI];
  assign miso_s = pins_sync[SYNC_MISO];

  // ---- register state
  logic [7:0]          ctl_reg;
  logic [7:0]          ctl_next;
  logic                done_reg;
  logic                done_next;
  logic                write_collision_flag_reg;
  logic                write_collision_flag_next;
  logic                select_early_release_flag_reg;
  logic                select_early_release_flag_next;
  logic                mode_fault_flag_reg;
  logic                mode_fault_flag_next;
  logic                done_arm_reg;
  logic                done_arm_next;
  logic                write_collision_flag_arm_reg;
  logic                write_collision_flag_arm_next;
  logic                mode_fault_flag_arm_reg;
  logic                mode_fault_flag_arm_next;
  logic [7:0]          rx_buf_reg;
  logic [7:0]          rx_buf_next;

  // ---- bus state
  logic                ack_reg;
  logic                ack_next;
  logic [DATA_W-1:0]   rdata_reg;
  logic [DATA_W-1:0]   rdata_next;
  logic                req;
  logic                acc;
  logic                hit_ctl;
  logic                hit_sta;
  logic                hit_dat;
  logic                ctl_wr;
  logic                sta_rd;
  logic                sta_acc;
  logic                dat_rd;
  logic                dat_wr;
  logic                dat_acc;
  logic [7:0]          wbyte;

  // ---- engine state
  spifec_state_t       state_reg;
  spifec_state_t       state_next;
  logic [2:0]          cnt_reg;
  logic [2:0]          cnt_next;
  logic [7:0]          sh_reg;
  logic [7:0]          sh_next;
  logic                latch_reg;
  logic                latch_next;
  logic                half_reg;
  logic                half_next;
  logic                sck_lvl_reg;
  logic                sck_lvl_next;
  logic                out_bit_reg;
  logic                out_bit_next;
  logic                sck_prev_reg;
  logic                ss_prev_reg;

  // ---- engine events and decoded control
  logic                en;
  logic                master;
  logic                idle_lvl;
  logic                phase;
  logic                ignore;
  logic                ss_sel;
  logic                ss_fall;
  logic                tick;
  logic                busy;
  logic                mode_fault_flag_evt;
  logic                done_evt;
  logic                write_collision_flag_evt;
  logic                select_early_release_flag_evt;
  logic [7:0]          rx_byte;
  logic                in_bit;
  logic                done_clr;

  assign en       = ctl_reg[CTL_ENABLE];
  assign master   = ctl_reg[CTL_CONTROLLER];
  assign idle_lvl = ctl_reg[CTL_IDLE];
  assign phase    = ctl_reg[CTL_PHASE];
  assign ignore   = ctl_reg[CTL_IGNORE];

  // ---- bus decode: one wait state, then the access takes effect
  assign req     = avs_read_i | avs_write_i;
  assign acc     = req & ack_reg;
  assign hit_ctl = (avs_address_i == ADDR_CONTROL);
  assign hit_sta = (avs_address_i == ADDR_STATUS);
  assign hit_dat = (avs_address_i == ADDR_DATA);
  assign wbyte   = avs_writedata_i[BYTE_W-1:0];
  assign ctl_wr  = acc & avs_write_i & hit_ctl & avs_byteenable_i[0];
  assign sta_rd  = acc & avs_read_i & hit_sta;
  assign sta_acc = acc & hit_sta;
  assign dat_rd  = acc & avs_read_i & hit_dat;
  assign dat_wr  = acc & avs_write_i & hit_dat & avs_byteenable_i[0];
  assign dat_acc = dat_rd | dat_wr;

  // read data is captured in the wait cycle, so it stands at the release edge
  always_comb begin
    ack_next   = req & ~ack_reg;
    rdata_next = rdata_reg;
    if (req && !ack_reg) begin
      if (hit_ctl) begin
        rdata_next = {24'h000000, ctl_reg};
      end else if (hit_sta) begin
        rdata_next = {24'h000000, done_reg, write_collision_flag_reg, select_early_release_flag_reg, mode_fault_flag_reg, 4'h0};
      end else if (hit_dat) begin
        rdata_next = {24'h000000, rx_buf_reg};
      end else begin
        rdata_next = '0;
      end
    end
  end

  // bus registers
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ack_reg   <= 1'b0;
      rdata_reg <= '0;
    end else begin
      ack_reg   <= ack_next;
      rdata_reg <= rdata_next;
    end
  end

  assign avs_waitrequest_o = req & ~ack_reg;
  assign avs_readdata_o    = rdata_reg;

  // ---- serial edge detection on synchronised levels
  assign ss_sel  = ~ss_n_s | (ignore & phase);
  assign ss_fall = ss_prev_reg & ~ss_n_s;
  assign busy    = master ? (state_reg == SPIFEC_SHIFT) : ((cnt_reg != 3'h0) | half_reg);
  assign mode_fault_flag_evt = en & master & ~ignore & ss_fall;
  assign in_bit  = master ? miso_s : mosi_s;

  // master clock divider, running only while a master byte shifts
  spifec_rate_div u_div (
    .core_clk_i (core_clk_i),
    .reset_n_i  (reset_n_i),
    .run_i      (en & master & (state_reg == SPIFEC_SHIFT)),
    .rate_i     ({ctl_reg[CTL_RATE_HIGH], ctl_reg[CTL_RATE_MID], ctl_reg[CTL_RATE_LOW]}),
    .tick_o     (tick)
  );

  // ---- shift engine next state
  always_comb begin
    state_next   = state_reg;
    cnt_next     = cnt_reg;
    sh_next      = sh_reg;
    latch_next   = latch_reg;
    half_next    = half_reg;
    sck_lvl_next = sck_lvl_reg;
    out_bit_next = out_bit_reg;
    done_evt     = 1'b0;
    write_collision_flag_evt     = 1'b0;
    select_early_release_flag_evt    = 1'b0;
    rx_byte      = {sh_reg[6:0], phase ? in_bit : latch_reg};
    if (!en || mode_fault_flag_evt) begin
      // disable or fault parks the engine
      state_next   = SPIFEC_IDLE;
      cnt_next     = 3'h0;
      half_next    = 1'b0;
      sck_lvl_next = idle_lvl;
    end else if (master) begin
      if (state_reg == SPIFEC_IDLE) begin
        sck_lvl_next = idle_lvl;
        if (dat_wr) begin
          sh_next      = wbyte;
          out_bit_next = wbyte[BYTE_W-1];
          state_next   = SPIFEC_SHIFT;
          cnt_next     = 3'h0;
        end
      end else begin
        write_collision_flag_evt = dat_wr;
        if (tick) begin
          sck_lvl_next = ~sck_lvl_reg;
          if (sck_lvl_reg == idle_lvl) begin
            // leading edge: phase 0 samples, phase 1 drives
            if (!phase) begin
              latch_next = in_bit;
            end else begin
              out_bit_next = sh_reg[7];
            end
          end else begin
            // trailing edge: phase 0 shifts out, phase 1 samples
            sh_next = rx_byte;
            if (!phase) begin
              out_bit_next = sh_reg[6];
            end
            cnt_next = cnt_reg + 3'h1;
            if (cnt_reg == LAST_BIT) begin
              done_evt   = 1'b1;
              state_next = SPIFEC_IDLE;
            end
          end
        end
      end
    end else begin
      sck_lvl_next = idle_lvl;
      if (dat_wr) begin
        if (busy) begin
          write_collision_flag_evt = 1'b1;
        end else begin
          sh_next      = wbyte;
          out_bit_next = wbyte[BYTE_W-1];
        end
      end
      if (!ss_sel) begin
        // deselected slave drops any partial byte
        select_early_release_flag_evt = busy;
        cnt_next  = 3'h0;
        half_next = 1'b0;
      end else begin
        if (ss_fall && !phase) begin
          out_bit_next = sh_reg[7];
        end
        if (sck_s != sck_prev_reg) begin
          if (sck_s != idle_lvl) begin
            half_next = 1'b1;
            if (!phase) begin
              latch_next = in_bit;
            end else begin
              out_bit_next = sh_reg[7];
            end
          end else if (half_reg) begin
            half_next = 1'b0;
            sh_next   = rx_byte;
            if (!phase) begin
              out_bit_next = sh_reg[6];
            end
            cnt_next = cnt_reg + 3'h1;
            done_evt = (cnt_reg == LAST_BIT);
          end
        end
      end
    end
  end

  // shift engine registers
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_reg    <= SPIFEC_IDLE;
      cnt_reg      <= 3'h0;
      sh_reg       <= 8'h00;
      latch_reg    <= 1'b0;
      half_reg     <= 1'b0;
      sck_lvl_reg  <= 1'b0;
      out_bit_reg  <= 1'b0;
      sck_prev_reg <= 1'b0;
      ss_prev_reg  <= 1'b1;
    end else begin
      state_reg    <= state_next;
      cnt_reg      <= cnt_next;
      sh_reg       <= sh_next;
      latch_reg    <= latch_next;
      half_reg     <= half_next;
      sck_lvl_reg  <= sck_lvl_next;
      out_bit_reg  <= out_bit_next;
      sck_prev_reg <= sck_s;
      ss_prev_reg  <= ss_n_s;
    end
  end

  // ---- control register and flags; a hardware set wins over any clear
  assign done_clr = dat_rd & done_arm_reg;

  always_comb begin
    ctl_next      = ctl_reg;
    mode_fault_flag_arm_next = mode_fault_flag_arm_reg;
    done_arm_next = done_arm_reg;
    write_collision_flag_arm_next = write_collision_flag_arm_reg;
    rx_buf_next   = rx_buf_reg;
    mode_fault_flag_next     = mode_fault_flag_reg;
    select_early_release_flag_next    = select_early_release_flag_reg;
    // control write; enable stays low while a fault is pending
    if (ctl_wr) begin
      ctl_next = wbyte;
      if (mode_fault_flag_reg && !mode_fault_flag_arm_reg) begin
        ctl_next[CTL_ENABLE] = 1'b0;
      end
      if (mode_fault_flag_arm_reg) begin
        mode_fault_flag_next = 1'b0;
      end
      mode_fault_flag_arm_next = 1'b0;
      if (!wbyte[CTL_ENABLE]) begin
        select_early_release_flag_next = 1'b0;
      end
    end
    if (sta_rd && mode_fault_flag_reg) begin
      mode_fault_flag_arm_next = 1'b1;
    end
    // fault forces the port off and back to slave role
    if (mode_fault_flag_evt) begin
      mode_fault_flag_next                = 1'b1;
      ctl_next[CTL_ENABLE]     = 1'b0;
      ctl_next[CTL_CONTROLLER] = 1'b0;
    end
    if (select_early_release_flag_evt) begin
      select_early_release_flag_next = 1'b1;
    end
    // transfer done flag and its read sequence
    if (done_clr) begin
      done_arm_next = 1'b0;
    end else if (sta_rd && done_reg) begin
      done_arm_next = 1'b1;
    end
    done_next = done_evt | (done_reg & ~done_clr);
    // only the first byte after a clear lands in the buffer
    if (done_evt && (!done_reg || done_clr)) begin
      rx_buf_next = rx_byte;
    end
    // collision flag: any status access arms, a data access after it clears
    if (dat_acc && write_collision_flag_arm_reg) begin
      write_collision_flag_arm_next = 1'b0;
    end else if (sta_acc) begin
      write_collision_flag_arm_next = 1'b1;
    end
    write_collision_flag_next = write_collision_flag_evt | (write_collision_flag_reg & ~(dat_acc & write_collision_flag_arm_reg));
  end

  // control and flag registers
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ctl_reg      <= CONTROL_RESET;
      done_reg     <= 1'b0;
      write_collision_flag_reg     <= 1'b0;
      select_early_release_flag_reg    <= 1'b0;
      mode_fault_flag_reg     <= 1'b0;
      done_arm_reg <= 1'b0;
      write_collision_flag_arm_reg <= 1'b0;
      mode_fault_flag_arm_reg <= 1'b0;
      rx_buf_reg   <= 8'h00;
    end else begin
      ctl_reg      <= ctl_next;
      done_reg     <= done_next;
      write_collision_flag_reg     <= write_collision_flag_next;
      select_early_release_flag_reg    <= select_early_release_flag_next;
      mode_fault_flag_reg     <= mode_fault_flag_next;
      done_arm_reg <= done_arm_next;
      write_collision_flag_arm_reg <= write_collision_flag_arm_next;
      mode_fault_flag_arm_reg <= mode_fault_flag_arm_next;
      rx_buf_reg   <= rx_buf_next;
    end
  end

  // ---- pin drive
  assign sck_o     = sck_lvl_reg;
  assign sck_oe_o  = en & master;
  assign mosi_o    = out_bit_reg;
  assign mosi_oe_o = en & master;
  assign miso_o    = out_bit_reg;
  assign miso_oe_o = en & ~master & ss_sel;

  // ---- request outputs
  assign tx_irq_o     = done_reg;
  assign rx_err_irq_o = mode_fault_flag_reg & ~ignore;

endmodule // spifec_core

//--- spifec_pkg.sv
// spifec_pkg: constants shared by the serial port core and its helpers
// assumes a byte-addressed Avalon-MM slave with 32-bit data lanes
package spifec_pkg;

  // bus geometry
  localparam int unsigned ADDR_W = 10;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned BYTE_W = 8;

  // register indices; the byte address is four times the index
  localparam logic [7:0] IDX_CONTROL = 8'hc3;
  localparam logic [7:0] IDX_STATUS  = 8'hc4;
  localparam logic [7:0] IDX_DATA    = 8'hc5;
  localparam logic [ADDR_W-1:0] ADDR_CONTROL = {IDX_CONTROL, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_STATUS  = {IDX_STATUS, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_DATA    = {IDX_DATA, 2'b00};

  // control register fields
  localparam int unsigned CTL_RATE_HIGH  = 7;
  localparam int unsigned CTL_ENABLE     = 6;
  localparam int unsigned CTL_IGNORE     = 5;
  localparam int unsigned CTL_CONTROLLER = 4;
  localparam int unsigned CTL_IDLE       = 3;
  localparam int unsigned CTL_PHASE      = 2;
  localparam int unsigned CTL_RATE_MID   = 1;
  localparam int unsigned CTL_RATE_LOW   = 0;
  localparam logic [7:0]  CONTROL_RESET  = 8'h14;

  // status register fields
  localparam int unsigned STA_DONE  = 7;
  localparam int unsigned STA_WRITE_COLLISION_FLAG  = 6;
  localparam int unsigned STA_SELECT_EARLY_RELEASE_FLAG = 5;
  localparam int unsigned STA_MODE_FAULT_FLAG  = 4;

  // rate divider
  localparam int unsigned DIV_CNT_W = 7;
  localparam logic [2:0]  RATE_NONE = 3'h7;

  // bit counting within one byte
  localparam logic [2:0] LAST_BIT = 3'h7;

  // synchroniser lanes
  localparam int unsigned SYNC_W    = 4;
  localparam int unsigned SYNC_SCK  = 0;
  localparam int unsigned SYNC_SS   = 1;
  localparam int unsigned SYNC_MOSI = 2;
  localparam int unsigned SYNC_MISO = 3;

  typedef enum logic {SPIFEC_IDLE, SPIFEC_SHIFT} spifec_state_t;

endpackage

//--- spifec_sync.sv
// spifec_sync: two-flop synchroniser for a group of unrelated pin levels
// assumes each lane is a slow level; no lane is sampled as a bus
`timescale 1ns/1ps
module spifec_sync #(
  parameter int unsigned WIDTH = 4
) (
  input  wire logic             core_clk_i,
  input  wire logic             reset_n_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] stable_reg;

  // first stage feeds only the second stage
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      meta_reg   <= '0;
      stable_reg <= '0;
    end else begin
      meta_reg   <= async_i;
      stable_reg <= meta_reg;
    end
  end

  assign sync_o = stable_reg;

endmodule // spifec_sync

//--- spifec_rate_div.sv
// spifec_rate_div: half-period tick generator for the master serial clock
// assumes run is held for the whole transfer; code 111 gives no tick
`timescale 1ns/1ps
module spifec_rate_div
  import spifec_pkg::*;
(
  input  wire logic       core_clk_i,
  input  wire logic       reset_n_i,
  input  wire logic       run_i,
  input  wire logic [2:0] rate_i,
  output logic            tick_o
);

  logic [DIV_CNT_W-1:0] cnt_reg;
  logic [DIV_CNT_W-1:0] cnt_next;
  logic [DIV_CNT_W-1:0] limit;
  logic                 tick;

  // half period is 2**code cycles, so the full period is 2**(code+1)
  always_comb begin
    limit    = DIV_CNT_W'(DIV_CNT_W'(1) << rate_i) - DIV_CNT_W'(1);
    tick     = run_i && (rate_i != RATE_NONE) && (cnt_reg == limit);
    cnt_next = cnt_reg + DIV_CNT_W'(1);
    if (!run_i || tick || (rate_i == RATE_NONE)) begin
      cnt_next = '0;
    end
  end

  // counter register
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  assign tick_o = tick;

endmodule // spifec_rate_div

//--- spifec_properties.sv
// spifec_properties: port-level checks of the serial port core
// assumes it is bound to spifec_core and sees only its ports
`timescale 1ns/1ps
module spifec_props
  import spifec_pkg::*;
(
  input wire logic                       core_clk_i,
  input wire logic                       reset_n_i,
  input wire logic [spifec_pkg::ADDR_W-1:0] avs_address_i,
  input wire logic                       avs_read_i,
  input wire logic                       avs_write_i,
  input wire logic [spifec_pkg::DATA_W-1:0] avs_readdata_o,
  input wire logic                       avs_waitrequest_o,
  input wire logic                       sck_oe_o,
  input wire logic                       mosi_oe_o,
  input wire logic                       miso_oe_o,
  input wire logic                       tx_irq_o,
  input wire logic                       rx_err_irq_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);
  // one wait state on every new request
  a_wait_state: assert property (($rose(avs_read_i) || $rose(avs_write_i)) |->
    avs_waitrequest_o ##1 !avs_waitrequest_o) else $error("wait state wrong");
  a_oe_pair: assert property (sck_oe_o == mosi_oe_o)
    else $error("master enables differ");
  a_role_exclusive: assert property (!(sck_oe_o && miso_oe_o))
    else $error("master and slave drive");
  a_fault_master: assert property ($rose(rx_err_irq_o) |-> $past(sck_oe_o))
    else $error("fault outside master role");
  a_fault_disable: assert property ($rose(rx_err_irq_o) |-> ##[0:1] !sck_oe_o)
    else $error("fault left port driving");
  a_done_clear: assert property ($fell(tx_irq_o) |->
    $past(avs_read_i && avs_address_i == ADDR_DATA)) else $error("done fell alone");
  a_fault_clear: assert property ($fell(rx_err_irq_o) |->
    $past(avs_write_i && avs_address_i == ADDR_CONTROL)) else $error("fault fell alone");
  a_upper_zero: assert property (avs_readdata_o[31:8] == 24'h0)
    else $error("upper read bits set");
  c_done: cover property ($rose(tx_irq_o));
  c_fault: cover property ($rose(rx_err_irq_o));
  c_clear: cover property ($fell(tx_irq_o));
endmodule // spifec_props

bind spifec_core spifec_props chk_i (.core_clk_i, .reset_n_i, .avs_address_i, .avs_read_i,
  .avs_write_i, .avs_readdata_o, .avs_waitrequest_o, .sck_oe_o, .mosi_oe_o, .miso_oe_o,
  .tx_irq_o, .rx_err_irq_o);

//--- spifec_slave_model.sv
// spifec_slave_model: behavioural serial slave on the far side of the port
// assumes sck and mosi come from the port in master role; ss_n is driven by the testbench
`timescale 1ns/1ps
module spifec_slave_model (
  input  wire logic       sck,
  input  wire logic       ss_n,
  input  wire logic       mosi,
  input  wire logic [1:0] mode,
  input  wire logic [7:0] tx_byte,
  output logic            miso,
  output logic [7:0]      rx_byte
);
  logic [7:0] sh = 8'h00;
  initial miso = 1'b0;
  initial rx_byte = 8'h00;
  // load on select; phase 0 shows the msb before the first edge
  always @(negedge ss_n) begin
    sh = tx_byte;
    if (!mode[0]) begin
      miso = sh[7];
      sh = sh << 1;
    end
  end
  // a released line shows the inverse, never the held value
  always @(posedge ss_n) miso = ~miso;
  // leading edge leaves the idle level; phase picks sample or shift
  always @(sck) begin
    if (!ss_n && ((sck != mode[1]) == !mode[0])) rx_byte = {rx_byte[6:0], mosi};
    else if (!ss_n) begin
      miso = sh[7];
      sh = sh << 1;
    end
  end
endmodule // spifec_slave_model

//--- test_spi_format_error_control.sv
// test_spi_format_error_control: register-level test of the serial port core
// assumes the core in master role against a behavioural slave, then in slave role
`timescale 1ns/1ps
module test_spi_format_error_control;
  import spifec_pkg::*;
  logic              core_clk_i = 0, reset_n_i = 0, avs_read_i = 0, avs_write_i = 0;
  logic              ss_n_i = 1, slv_ss_n = 1, avs_waitrequest_o, sck_o, sck_oe_o;
  logic              ext_sck = 0, ext_mosi = 0;
  logic              mosi_o, mosi_oe_o, miso_i, miso_o, miso_oe_o, tx_irq_o, rx_err_irq_o;
  logic [ADDR_W-1:0] avs_address_i = '0;
  logic [DATA_W-1:0] avs_writedata_i = '0, avs_readdata_o;
  logic [7:0]        slv_tx = 8'h00, slv_rx, q;
  logic [1:0]        mode = 2'b00;
  logic [2:0]        c;
  int                bad_count = 0, compares = 0, n;

  spifec_core uut (.core_clk_i, .reset_n_i, .avs_address_i, .avs_read_i, .avs_write_i,
    .avs_writedata_i, .avs_byteenable_i(4'h1), .avs_readdata_o, .avs_waitrequest_o,
    .sck_i(ext_sck), .sck_o, .sck_oe_o, .mosi_i(ext_mosi), .mosi_o, .mosi_oe_o, .miso_i, .miso_o,
    .miso_oe_o, .ss_n_i, .tx_irq_o, .rx_err_irq_o);
  spifec_slave_model slv (.sck(sck_o), .ss_n(slv_ss_n), .mosi(mosi_o), .mode, .tx_byte(slv_tx),
    .miso(miso_i), .rx_byte(slv_rx));

  initial forever #2.5 core_clk_i = ~core_clk_i;
  // cut a hang short
  initial begin
    repeat (30000) @(posedge core_clk_i);
    bad_count++;
    stop_test();
  end

  task automatic stop_test();
    if (bad_count == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // one bus access held until waitrequest is sampled low
  task automatic acc(input logic w, input logic [9:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    avs_address_i <= a;
    avs_writedata_i <= {24'h0, d};
    avs_read_i <= !w;
    avs_write_i <= w;
    do @(posedge core_clk_i); while (avs_waitrequest_o !== 1'b0);
    q = avs_readdata_o[7:0];
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
  endtask

  task automatic wdone();
    n = 0;
    while (tx_irq_o !== 1'b1 && n < 5000) begin
      @(posedge core_clk_i);
      n++;
    end
  endtask

  // external master, phase 0 and idle low, 160 ns sck; miso gathered into q
  task automatic ext(input logic [7:0] b, input int bits);
    for (int i = 7; i > 7 - bits; i--) begin
      ext_mosi <= b[i];
      repeat (16) @(posedge core_clk_i);
      q = {q[6:0], miso_o};
      ext_sck <= 1'b1;
      repeat (16) @(posedge core_clk_i);
      ext_sck <= 1'b0;
    end
    repeat (16) @(posedge core_clk_i);
  endtask

  initial begin
    repeat (16) @(posedge core_clk_i);
    reset_n_i <= 1'b1;
    acc(0, ADDR_CONTROL, 8'h00);
    chk("ctl reset", q, 8'h14);
    acc(1, 10'h3fc, 8'h5a);
    acc(0, 10'h3fc, 8'h00);
    chk("unmapped", q, 8'h00);
    // every idle level and phase, a slower rate each time
    for (int m = 0; m < 4; m++) begin
      c = 3'(m + 2);
      acc(1, ADDR_CONTROL, {c[2], 3'b001, 2'(m), c[1:0]});
      mode <= 2'(m);
      acc(1, ADDR_CONTROL, {c[2], 3'b101, 2'(m), c[1:0]});
      chk("idle", {7'h0, sck_o}, {7'h0, mode[1]});
      slv_tx <= 8'ha5 ^ 8'(m);
      slv_ss_n <= 1'b0;
      acc(1, ADDR_DATA, 8'h3c + 8'(m));
      acc(1, ADDR_DATA, 8'hff);
      chk("drive", {6'h0, sck_oe_o, mosi_oe_o}, 8'h3);
      wdone();
      chk("rate", 8'(n >= (16 << c) - 4 && n <= (16 << c) + 8), 8'h1);
      chk("rx", slv_rx, 8'h3c + 8'(m));
      chk("end idle", {7'h0, sck_o}, {7'h0, mode[1]});
      slv_ss_n <= 1'b1;
      slv_tx <= 8'h11;
      @(posedge core_clk_i);
      slv_ss_n <= 1'b0;
      acc(1, ADDR_DATA, 8'h77);
      repeat ((16 << c) + 12) @(posedge core_clk_i);
      slv_ss_n <= 1'b1;
      acc(0, ADDR_STATUS, 8'h00);
      chk("status", q, 8'hc0);
      acc(0, ADDR_DATA, 8'h00);
      chk("data", q, 8'ha5 ^ 8'(m));
      acc(0, ADDR_STATUS, 8'h00);
      chk("cleared", q, 8'h00);
      acc(1, ADDR_CONTROL, {c[2], 3'b001, 2'(m), c[1:0]});
    end
    // select low against an enabled master
    acc(1, ADDR_CONTROL, 8'h52);
    ss_n_i <= 1'b0;
    n = 0;
    while (rx_err_irq_o !== 1'b1 && n < 20) begin
      @(posedge core_clk_i);
      n++;
    end
    chk("fault irq", {7'h0, rx_err_irq_o}, 8'h1);
    chk("fault oe", {7'h0, sck_oe_o}, 8'h0);
    acc(0, ADDR_CONTROL, 8'h00);
    chk("ctl fault", q, 8'h02);
    acc(0, ADDR_STATUS, 8'h00);
    chk("fault flag", q, 8'h10);
    acc(1, ADDR_CONTROL, 8'h02);
    ss_n_i <= 1'b1;
    acc(0, ADDR_STATUS, 8'h00);
    chk("fault clr", q, 8'h00);
    // ignored select never faults
    acc(1, ADDR_CONTROL, 8'h72);
    ss_n_i <= 1'b0;
    repeat (10) @(posedge core_clk_i);
    chk("ignored", {7'h0, rx_err_irq_o}, 8'h0);
    acc(0, ADDR_STATUS, 8'h00);
    chk("no fault", q, 8'h00);
    // slave role, phase 0 with the ignore bit set: select still frames bytes
    ss_n_i <= 1'b1;
    acc(1, ADDR_CONTROL, 8'h00);
    acc(1, ADDR_CONTROL, 8'h60);
    acc(1, ADDR_DATA, 8'hc6);
    ss_n_i <= 1'b0;
    ext(8'h5b, 8);
    chk("slave miso", q, 8'hc6);
    chk("miso drive", {7'h0, miso_oe_o}, 8'h1);
    chk("slave done", {7'h0, tx_irq_o}, 8'h1);
    ss_n_i <= 1'b1;
    acc(0, ADDR_STATUS, 8'h00);
    chk("slave sta", q, 8'h80);
    chk("miso float", {7'h0, miso_oe_o}, 8'h0);
    acc(0, ADDR_DATA, 8'h00);
    chk("slave rx", q, 8'h5b);
    // select released after three bits
    ss_n_i <= 1'b0;
    ext(8'h5b, 3);
    ss_n_i <= 1'b1;
    repeat (4) @(posedge core_clk_i);
    acc(0, ADDR_STATUS, 8'h00);
    chk("early rel", q, 8'h20);
    acc(1, ADDR_CONTROL, 8'h00);
    acc(0, ADDR_STATUS, 8'h00);
    chk("rel clr", q, 8'h00);
    stop_test();
  end
endmodule // test_spi_format_error_control
